/* hdl/uhsi_pkg.sv */
package uhsi_pkg;

    // Register byte offsets on the bus
    localparam int ADDR_WIDTH = 8;
    localparam logic [7:0] STATUS_OFFSET = 8'h14;
    localparam logic [7:0] ENABLE_OFFSET = 8'h18;

    // Status register field positions
    localparam int ASYNC_RUNNING_BIT = 15;
    localparam int PERIODIC_RUNNING_BIT = 14;
    localparam int RECLAIM_BIT = 13;
    localparam int STOPPED_BIT = 12;
    localparam int ADVANCE_BIT = 5;
    localparam int SYSERR_BIT = 4;
    localparam int WRAP_BIT = 3;
    localparam int PORT_BIT = 2;
    localparam int XFER_ERROR_BIT = 1;
    localparam int XFER_DONE_BIT = 0;

    // Sticky event flags occupy bits [5:0] of status and enables
    localparam int FLAG_COUNT = 6;
    localparam logic [5:0] PACED_MASK = 6'h23;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [5:0] ENABLES_RESET = 6'h00;
    localparam logic STOPPED_RESET = 1'b1;

    // Threshold field values
    localparam logic [7:0] RATE_LIMIT_DEFAULT = 8'h08;
    localparam logic [7:0] RATE_NO_LIMIT = 8'h01;

    // Micro-frame timing at the 40 MHz system clock
    localparam int CLOCK_KHZ = 40000;
    localparam int MICROFRAME_US = 125;
    localparam int MICROFRAME_CYCLES = MICROFRAME_US * CLOCK_KHZ / 1000;

    // Controller halt sequencing
    typedef enum logic [2:0] {
        ST_HALTED = 3'b001,
        ST_RUNNING = 3'b010,
        ST_STOPPING = 3'b100
    } uhsi_halt_state_t;

endpackage

/* hdl/uhsi_avmm_slave.sv */
`timescale 1ns/1ps
module uhsi_avmm_slave (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [31:0] read_value,
    output logic reg_write
);
    logic ack_reg;
    logic [31:0] readdata_reg;

    // One wait cycle, then the access completes
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    // Read word captured during the wait cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            readdata_reg <= 32'h0000_0000;
        end else if (read & ~ack_reg) begin
            readdata_reg <= read_value;
        end
    end

    assign waitrequest = (read | write) & ~ack_reg;
    assign readdata = readdata_reg;
    assign reg_write = write & ack_reg; // Edge where waitrequest is low

endmodule

/* hdl/uhsi_irq_pacer.sv */
`timescale 1ns/1ps
module uhsi_irq_pacer #(
    parameter int MICROFRAME_CYCLES = uhsi_pkg::MICROFRAME_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] rate_limit,
    output logic boundary
);
    localparam int CW = $clog2(MICROFRAME_CYCLES + 1);
    localparam logic [CW-1:0] LAST_CYCLE = CW'(MICROFRAME_CYCLES - 1);

    logic [CW-1:0] cycle_reg;
    logic [7:0] uframe_reg;
    logic boundary_reg;
    logic uframe_tick;
    logic [8:0] uframe_sum;

    assign uframe_tick = (cycle_reg == LAST_CYCLE);
    assign uframe_sum = {1'b0, uframe_reg} + 9'h001;

    // Micro-frame timebase
    always_ff @(posedge clock) begin
        if (rst) begin
            cycle_reg <= '0;
        end else if (uframe_tick) begin
            cycle_reg <= '0;
        end else begin
            cycle_reg <= cycle_reg + CW'(1);
        end
    end

    // Counts micro-frames up to the programmed interval
    always_ff @(posedge clock) begin
        if (rst) begin
            uframe_reg <= 8'h00;
            boundary_reg <= 1'b0;
        end else begin
            boundary_reg <= 1'b0;
            if (uframe_tick) begin
                if (uframe_sum >= {1'b0, rate_limit}) begin
                    uframe_reg <= 8'h00;
                    boundary_reg <= 1'b1;
                end else begin
                    uframe_reg <= uframe_sum[7:0];
                end
            end
        end
    end

    assign boundary = boundary_reg;

endmodule

/* hdl/uhsi_status_irq.sv */
`timescale 1ns/1ps
// Operation
// - Writing one to an event flag clears it; writing zero leaves it.
// - Status shows only pending events and controller states, no transaction results.
// - Bit 15 shows the asynchronous schedule running; resets to zero.
// - Bit 14 shows the periodic schedule running; resets to zero.
// - Bit 13 is the reclamation indicator for empty async schedule; resets zero.
// - Stopped bit 12 resets to one and reads zero while run/stop is one.
// - Stopped bit sets only after schedule execution has really stopped.
// - Bit 5 sets on the async advance event and stays until cleared.
// - Bit 4 sets on a serious system memory access error.
// - Bit 3 sets when the frame list index wraps to zero.
// - Bit 2 sets when any port change bit rises.
// - Bit 2 is also loaded with the OR of all port change bits.
// - Bit 1 sets when a completed transaction ends in error.
// - Bit 0 sets when a transaction completes.
// - Interrupt raised only when a source is both enabled and flagged.
// - Flags still set while their enables are clear.
// - Sources 5, 1 and 0 wait for the next threshold boundary.
// - Sources 4, 3 and 2 interrupt as soon as enabled and flagged.
// - Threshold 01h passes paced events with no interval delay.
// - Threshold selects interval in micro-frames; default 08h is one millisecond.
// - Run/stop one runs the schedules; zero requests a stop.
module uhsi_status_irq #(
    parameter int PORT_COUNT = 1,
    parameter int MICROFRAME_CYCLES = uhsi_pkg::MICROFRAME_CYCLES
) (
    input wire logic clock,
    input wire logic rst,

    // Avalon-MM register slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,

    // Command-side controls
    input wire logic run_stop_control,
    input wire logic [7:0] irq_rate_limit,

    // Schedule engine states
    input wire logic async_schedule_running,
    input wire logic periodic_schedule_running,
    input wire logic reclamation,
    input wire logic schedules_idle,

    // Schedule engine event strobes
    input wire logic async_advance_event,
    input wire logic system_access_error_event,
    input wire logic frame_index_wrap_event,
    input wire logic transfer_error_event,
    input wire logic transfer_done_event,

    // Port status change bits, one per port
    input wire logic [PORT_COUNT-1:0] port_change_bits,

    // Host interrupt, active high level
    output logic host_irq
);

    // Flag vector layout, bit index equals status bit position
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic [5:0] flag_set;
    logic [5:0] flag_clear;
    logic [5:0] enables_reg;

    // State bits
    logic async_running_reg;
    logic periodic_running_reg;
    logic reclaim_reg;
    logic controller_stopped;
    uhsi_pkg::uhsi_halt_state_t halt_state_reg;
    uhsi_pkg::uhsi_halt_state_t halt_state_next;

    // Port change edge detection
    logic [PORT_COUNT-1:0] port_prev_reg;
    logic port_rise;
    logic port_any;

    // Register access
    logic reg_write;
    logic [31:0] read_value;
    logic status_hit;
    logic enable_hit;

    // Interrupt pacing
    logic threshold_boundary;
    logic [5:0] active_sources;
    logic paced_active;
    logic direct_active;
    logic no_limit;
    logic paced_irq_reg;
    logic host_irq_reg;

    // Bus slave with one wait cycle
    uhsi_avmm_slave u_slave (
        .clock(clock),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .read_value(read_value),
        .reg_write(reg_write)
    );

    // Threshold boundary timer
    uhsi_irq_pacer #(
        .MICROFRAME_CYCLES(MICROFRAME_CYCLES)
    ) u_pacer (
        .clock(clock),
        .rst(rst),
        .rate_limit(irq_rate_limit),
        .boundary(threshold_boundary)
    );

    // Address decode
    assign status_hit = (address == uhsi_pkg::STATUS_OFFSET);
    assign enable_hit = (address == uhsi_pkg::ENABLE_OFFSET);

    // Read mux; unmapped offsets read zero
    always_comb begin
        read_value = 32'h0000_0000;
        if (status_hit) begin
            // Only event and state bits, nothing per transaction
            read_value[5:0] = flags_reg;
            read_value[uhsi_pkg::STOPPED_BIT] = controller_stopped;
            read_value[uhsi_pkg::RECLAIM_BIT] = reclaim_reg;
            read_value[uhsi_pkg::PERIODIC_RUNNING_BIT] = periodic_running_reg;
            read_value[uhsi_pkg::ASYNC_RUNNING_BIT] = async_running_reg;
        end else if (enable_hit) begin
            read_value[5:0] = enables_reg;
        end
    end

    // Schedule state snapshots
    always_ff @(posedge clock) begin
        if (rst) begin
            async_running_reg <= 1'b0;
            periodic_running_reg <= 1'b0;
            reclaim_reg <= 1'b0;
        end else begin
            async_running_reg <= async_schedule_running;
            periodic_running_reg <= periodic_schedule_running;
            reclaim_reg <= reclamation;
        end
    end

    // Halt sequencing
    always_comb begin
        halt_state_next = halt_state_reg;
        case (halt_state_reg)
            uhsi_pkg::ST_HALTED: begin
                if (run_stop_control) begin
                    halt_state_next = uhsi_pkg::ST_RUNNING;
                end
            end
            uhsi_pkg::ST_RUNNING: begin
                if (!run_stop_control) begin
                    halt_state_next = uhsi_pkg::ST_STOPPING;
                end
            end
            uhsi_pkg::ST_STOPPING: begin
                if (run_stop_control) begin
                    halt_state_next = uhsi_pkg::ST_RUNNING;
                end else if (schedules_idle) begin
                    halt_state_next = uhsi_pkg::ST_HALTED;
                end
            end
            default: begin
                halt_state_next = uhsi_pkg::ST_HALTED;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            halt_state_reg <= uhsi_pkg::ST_HALTED;
        end else begin
            halt_state_reg <= halt_state_next;
        end
    end

    // Stopped reads zero at once while run/stop is set
    assign controller_stopped = (halt_state_reg == uhsi_pkg::ST_HALTED)
                                & ~run_stop_control;

    // Port change edges and level
    always_ff @(posedge clock) begin
        if (rst) begin
            port_prev_reg <= '0;
        end else begin
            port_prev_reg <= port_change_bits;
        end
    end

    assign port_rise = |(port_change_bits & ~port_prev_reg);
    assign port_any = |port_change_bits;

    // Event set terms, independent of the enables
    always_comb begin
        flag_set = 6'h00;
        flag_set[uhsi_pkg::ADVANCE_BIT] = async_advance_event;
        flag_set[uhsi_pkg::SYSERR_BIT] = system_access_error_event;
        flag_set[uhsi_pkg::WRAP_BIT] = frame_index_wrap_event;
        flag_set[uhsi_pkg::PORT_BIT] = port_rise | port_any;
        flag_set[uhsi_pkg::XFER_ERROR_BIT] = transfer_error_event;
        flag_set[uhsi_pkg::XFER_DONE_BIT] = transfer_done_event;
    end

    // Write-one-to-clear on byte lane 0
    assign flag_clear = (reg_write & status_hit & byteenable[0])
                        ? writedata[5:0] : 6'h00;

    // Per-flag sticky logic; a set in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < uhsi_pkg::FLAG_COUNT; gi++) begin : g_flag
            always_comb begin
                flags_next[gi] = flags_reg[gi];
                if (flag_clear[gi]) begin
                    flags_next[gi] = 1'b0;
                end
                if (flag_set[gi]) begin
                    flags_next[gi] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst) begin
            flags_reg <= uhsi_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clock) begin
        if (rst) begin
            enables_reg <= uhsi_pkg::ENABLES_RESET;
        end else if (reg_write & enable_hit & byteenable[0]) begin
            enables_reg <= writedata[5:0];
        end
    end

    // Sources both enabled and flagged
    assign active_sources = flags_reg & enables_reg;
    assign paced_active = |(active_sources & uhsi_pkg::PACED_MASK);
    assign direct_active = |(active_sources & ~uhsi_pkg::PACED_MASK);

    // Reserved 00h is treated like 01h
    assign no_limit = (irq_rate_limit <= uhsi_pkg::RATE_NO_LIMIT);

    // Paced request latches at a boundary, drops once sources go quiet
    always_ff @(posedge clock) begin
        if (rst) begin
            paced_irq_reg <= 1'b0;
        end else if (!paced_active) begin
            paced_irq_reg <= 1'b0;
        end else if (threshold_boundary) begin
            paced_irq_reg <= 1'b1;
        end
    end

    // Combined host interrupt
    always_ff @(posedge clock) begin
        if (rst) begin
            host_irq_reg <= 1'b0;
        end else begin
            host_irq_reg <= direct_active
                            | (paced_active & no_limit)
                            | (paced_active & paced_irq_reg);
        end
    end

    assign host_irq = host_irq_reg;

endmodule

/* dv/uhsi_status_irq_checker.sv */
`timescale 1ns/1ps
module uhsi_status_irq_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic run_stop_control,
    input wire logic async_schedule_running,
    input wire logic reclamation,
    input wire logic host_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Read completing in this cycle
    wire logic rd_done = read && !waitrequest;
    wire logic rd_stat = rd_done && address == uhsi_pkg::STATUS_OFFSET;

    a_wait_first_cycle: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait state on new request");
    a_single_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request held beyond one wait state");
    a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest without request");
    a_irq_reset_low: assert property (disable iff (1'b0) rst |=> !host_irq)
        else $error("interrupt high after reset");
    a_status_reserved_zero: assert property (rd_stat
        |-> readdata[31:16] == 16'h0000 && readdata[11:6] == 6'h00)
        else $error("reserved status bits set");
    a_unmapped_read_zero: assert property (rd_done && address != uhsi_pkg::STATUS_OFFSET
        && address != uhsi_pkg::ENABLE_OFFSET |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_enable_reserved_zero: assert property (rd_done && address == uhsi_pkg::ENABLE_OFFSET
        |-> readdata[31:6] == 26'h0)
        else $error("reserved enable bits set");
    a_run_not_stopped: assert property (rd_stat
        && $past(run_stop_control) && $past(run_stop_control, 2) |-> !readdata[12])
        else $error("stopped bit set while running");
    a_async_bit_tracks: assert property (rd_stat
        && $past(async_schedule_running, 2) == $past(async_schedule_running, 3)
        |-> readdata[15] == $past(async_schedule_running, 2))
        else $error("async running bit wrong");
    a_reclaim_bit_tracks: assert property (rd_stat
        && $past(reclamation, 2) == $past(reclamation, 3)
        |-> readdata[13] == $past(reclamation, 2))
        else $error("reclamation bit wrong");

    // Main scenarios
    c_status_read: cover property (rd_stat && readdata[5:0] != 6'h00);
    c_irq_rise: cover property ($rose(host_irq));
    c_irq_fall: cover property ($fell(host_irq));
endmodule

bind uhsi_status_irq uhsi_status_irq_checker u_uhsi_status_irq_checker (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .run_stop_control(run_stop_control),
    .async_schedule_running(async_schedule_running), .reclamation(reclamation),
    .host_irq(host_irq)
);

/* dv/tb_usb_host_status_interrupt.sv */
`timescale 1ns/1ps
module tb_usb_host_status_interrupt;
    logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, rsc = 1'b0, idle = 1'b1;
    logic [7:0] address = 8'h00, rate = 8'h02;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic waitrequest, host_irq;
    logic [2:0] sched = 3'h0;
    logic [5:0] ev = 6'h00;
    logic [3:0] be = 4'hf;
    int n_mismatch = 0, checked = 0, cyc = 0, t0;
    localparam logic [7:0] ST = uhsi_pkg::STATUS_OFFSET, EN = uhsi_pkg::ENABLE_OFFSET;

    uhsi_status_irq #(.PORT_COUNT(1), .MICROFRAME_CYCLES(20)) u_uhsi_status_irq (
        .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(be), .readdata(readdata),
        .waitrequest(waitrequest), .run_stop_control(rsc), .irq_rate_limit(rate),
        .async_schedule_running(sched[2]), .periodic_schedule_running(sched[1]),
        .reclamation(sched[0]), .schedules_idle(idle), .async_advance_event(ev[5]),
        .system_access_error_event(ev[4]), .frame_index_wrap_event(ev[3]),
        .transfer_error_event(ev[1]), .transfer_done_event(ev[0]),
        .port_change_bits(ev[2:2]), .host_irq(host_irq));

    // Clock and cycle count
    initial forever #12.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, entered and left just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        address <= a;
        writedata <= wd;
        if (w) write <= 1'b1;
        else read <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            n_mismatch++;
            conclude();
        end
        // Data taken and request dropped at the completing edge
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge clock);
        ev <= 6'h00;
        @(posedge clock);
    endtask

    task automatic irq_is(input logic exp);
        @(negedge clock);
        chk({31'h0, host_irq}, {31'h0, exp});
        @(posedge clock);
    endtask

    task automatic t_reset_values();
        rd_chk(ST, 32'h0000_1000);
        rd_chk(EN, 32'h0);
        bus(1'b1, 8'h1c, 32'h3f);
        rd_chk(8'h1c, 32'h0);
        rd_chk(EN, 32'h0);
        // Lane 0 disabled, so the enable write is dropped
        be <= 4'he;
        bus(1'b1, EN, 32'h3f);
        be <= 4'hf;
        rd_chk(EN, 32'h0);
    endtask

    task automatic t_sched_bits();
        for (int i = 0; i < 3; i++) begin
            sched <= 3'h1 << i;
            repeat (3) @(posedge clock);
            rd_chk(ST, 32'h1000 | (32'h2000 << i));
        end
        sched <= 3'h0;
        @(posedge clock);
    endtask

    task automatic t_flags();
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i);
            rd_chk(ST, 32'h1000 | (32'h1 << i));
            bus(1'b1, ST, ~(32'h1 << i) & 32'h3f);
            rd_chk(ST, 32'h1000 | (32'h1 << i));
            bus(1'b1, ST, 32'h1 << i);
            rd_chk(ST, 32'h1000);
        end
        ev <= 6'h04;
        bus(1'b1, ST, 32'h04);
        rd_chk(ST, 32'h1004);
        ev <= 6'h00;
        bus(1'b1, ST, 32'h04);
        rd_chk(ST, 32'h1000);
    endtask

    task automatic t_direct_irq();
        for (int i = 2; i < 5; i++) begin
            bus(1'b1, EN, 32'h1 << i);
            pulse(6'h01 << i);
            @(posedge clock);
            irq_is(1'b1);
            bus(1'b1, EN, 32'h0);
            irq_is(1'b0);
            bus(1'b1, EN, 32'h1 << i);
            irq_is(1'b1);
            bus(1'b1, ST, 32'h1 << i);
            irq_is(1'b0);
        end
    endtask

    task automatic t_paced_irq();
        int n;
        bus(1'b1, EN, 32'h01);
        pulse(6'h01);
        for (n = 0; n < 60 && host_irq !== 1'b1; n++) @(negedge clock);
        chk(n < 60, 1'b1);
        @(posedge clock);
        t0 = cyc;
        bus(1'b1, ST, 32'h01);
        while (cyc < t0 + 5) @(posedge clock);
        pulse(6'h01);
        while (cyc < t0 + 30) @(posedge clock);
        irq_is(1'b0);
        for (n = 0; n < 20 && host_irq !== 1'b1; n++) @(negedge clock);
        chk(n < 20 && cyc >= t0 + 37, 1'b1);
        @(posedge clock);
        rate <= uhsi_pkg::RATE_NO_LIMIT;
        bus(1'b1, EN, 32'h23);
        // Each paced source alone, no interval wait
        for (int i = 0; i < 6; i++) begin
            if (uhsi_pkg::PACED_MASK[i]) begin
                bus(1'b1, ST, 32'h3f);
                irq_is(1'b0);
                pulse(6'h01 << i);
                @(posedge clock);
                irq_is(1'b1);
            end
        end
        bus(1'b1, ST, 32'h3f);
        bus(1'b1, EN, 32'h0);
    endtask

    task automatic t_halt();
        idle <= 1'b0;
        rsc <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(ST, 32'h0);
        rsc <= 1'b0;
        repeat (3) @(posedge clock);
        rd_chk(ST, 32'h0);
        idle <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(ST, 32'h1000);
    endtask

    // Reset in mid-run drops the interrupt and restores defaults
    task automatic t_mid_reset();
        bus(1'b1, EN, 32'h10);
        pulse(6'h10);
        @(posedge clock);
        irq_is(1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        irq_is(1'b0);
        rd_chk(EN, 32'h0);
        rd_chk(ST, 32'h0000_1000);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset_values();
        t_sched_bits();
        t_flags();
        t_direct_irq();
        t_paced_irq();
        t_halt();
        t_mid_reset();
        conclude();
    end
endmodule
